//--- rtl/rtia_consts.svh
// Offsets, field positions, reset values and timing counts of the interrupt/alarm block
`ifndef RTIA_CONSTS_SVH
`define RTIA_CONSTS_SVH

// Register offsets on the local register port
`define RTIA_OFF_CTRL_A      4'h0
`define RTIA_OFF_CTRL_B      4'h1
`define RTIA_OFF_FLAGS       4'h2
`define RTIA_OFF_SEC         4'h3
`define RTIA_OFF_ALM_SEC     4'h4
`define RTIA_OFF_MIN         4'h5
`define RTIA_OFF_ALM_MIN     4'h6
`define RTIA_OFF_HOUR        4'h7
`define RTIA_OFF_ALM_HOUR    4'h8

// Control A fields
`define RTIA_A_UIP           7
// Control B fields
`define RTIA_B_FREEZE        7
`define RTIA_B_PER_EN        6
`define RTIA_B_ALM_EN        5
`define RTIA_B_UPD_EN        4
// Flag register fields
`define RTIA_F_SUMMARY       7
`define RTIA_F_PERIODIC      6
`define RTIA_F_ALARM         5
`define RTIA_F_UPDATE        4

// Reset values
`define RTIA_RST_CTRL_A      8'h00
`define RTIA_RST_CTRL_B      8'h00
`define RTIA_RST_ALARM       8'h00

// Timing
`define RTIA_CLK_HZ          50000000
`define RTIA_REF_HZ          32768
`define RTIA_PRESCALE        (`RTIA_CLK_HZ / `RTIA_REF_HZ)
`define RTIA_PRE_UPDATE_NS   244000
`define RTIA_UPDATE_NS       1000
`define RTIA_PRE_UPDATE_CYC  ((`RTIA_PRE_UPDATE_NS * (`RTIA_CLK_HZ / 1000000)) / 1000)
`define RTIA_UPDATE_CYC      ((`RTIA_UPDATE_NS * (`RTIA_CLK_HZ / 1000000)) / 1000)

`endif

//--- rtl/rtia_pkg.sv
// Types shared by the interrupt/alarm block
package rtia_pkg;

    typedef enum logic [2:0]
    {
        RTIA_SEQ_IDLE = 3'b001,
        RTIA_SEQ_PRE  = 3'b010,
        RTIA_SEQ_UPD  = 3'b100
    } rtia_seq_state_t;

endpackage : rtia_pkg

//--- rtl/rtia_divider.sv
// Reference tick prescaler, 15-stage divider chain and periodic tap selector
`include "rtia_consts.svh"

module rtia_divider #(
    parameter int PRESCALE = `RTIA_PRESCALE
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] rate_select_i,
    output logic            periodic_ev_o,
    output logic            second_tick_o
);

    logic [15:0] pre_cnt;
    logic        ref_tick;
    logic [14:0] chain;

    // Codes 1 and 2 repeat the taps of codes 8 and 9
    function automatic logic [14:0] rtia_tap_mask(input logic [3:0] rs);
        logic [3:0] len;
        len = (rs == 4'h1) ? 4'h7 : (rs == 4'h2) ? 4'h8 : rs - 4'h1;
        rtia_tap_mask = 15'((16'h1 << len) - 16'h1);
    endfunction : rtia_tap_mask

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pre_cnt  <= 16'h0;
            ref_tick <= 1'b0;
        end
        else
        begin
            ref_tick <= (pre_cnt == 16'(PRESCALE - 1));
            pre_cnt  <= (pre_cnt == 16'(PRESCALE - 1)) ? 16'h0 : pre_cnt + 16'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            chain         <= 15'h0;
            periodic_ev_o <= 1'b0;
            second_tick_o <= 1'b0;
        end
        else
        begin
            if (ref_tick)
                chain <= chain + 15'h1;
            periodic_ev_o <= ref_tick && (rate_select_i != 4'h0) &&
                             ((chain & rtia_tap_mask(rate_select_i)) ==
                              rtia_tap_mask(rate_select_i));
            second_tick_o <= ref_tick && (chain == 15'h7fff);
        end
    end

endmodule : rtia_divider

//--- rtl/rtia_alarm_cmp.sv
// Alarm byte comparator with don't-care codes
module rtia_alarm_cmp (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       compare_i,
    input  wire logic [7:0] alm_sec_i,
    input  wire logic [7:0] alm_min_i,
    input  wire logic [7:0] alm_hour_i,
    input  wire logic [7:0] cur_sec_i,
    input  wire logic [7:0] cur_min_i,
    input  wire logic [7:0] cur_hour_i,
    output logic            match_o
);

    // Both top bits set means the byte matches anything
    function automatic logic rtia_byte_hit(input logic [7:0] alm, input logic [7:0] cur);
        rtia_byte_hit = (alm[7:6] == 2'b11) || (alm == cur);
    endfunction : rtia_byte_hit

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            match_o <= 1'b0;
        else
            match_o <= compare_i &&
                       rtia_byte_hit(alm_sec_i, cur_sec_i) &&
                       rtia_byte_hit(alm_min_i, cur_min_i) &&
                       rtia_byte_hit(alm_hour_i, cur_hour_i);
    end

    chk_alarm_wildcard: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (compare_i && alm_sec_i[7:6] == 2'b11 && alm_min_i[7:6] == 2'b11 &&
         alm_hour_i[7:6] == 2'b11) |=> match_o)
        else $error("all-wildcard alarm did not match");

endmodule : rtia_alarm_cmp

//--- rtl/rtia_core.sv
// Interrupt, alarm and update-cycle logic of the clock/calendar with its register port
`include "rtia_consts.svh"

module rtia_core #(
    parameter int PRESCALE       = `RTIA_PRESCALE,
    parameter int PRE_UPDATE_CYC = `RTIA_PRE_UPDATE_CYC,
    parameter int UPDATE_CYC     = `RTIA_UPDATE_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic [7:0] cur_sec_i,
    input  wire logic [7:0] cur_min_i,
    input  wire logic [7:0] cur_hour_i,
    output logic            time_advance_o,
    output logic            irq_out_o,
    output logic            irq_oe_o
);

    logic [7:0]                ctrl_a;
    logic [7:0]                ctrl_b;
    logic [7:0]                alm_sec;
    logic [7:0]                alm_min;
    logic [7:0]                alm_hour;
    logic [2:0]                flags;
    logic [2:0]                held;
    logic [2:0]                events;
    logic [2:0]                enables;
    logic                      pend;
    logic                      rd_flags;
    logic                      periodic_ev;
    logic                      second_tick;
    logic                      alarm_ev;
    logic                      update_ev;
    logic                      uip;
    logic [15:0]               seq_cnt;
    rtia_pkg::rtia_seq_state_t seq_state;
    rtia_pkg::rtia_seq_state_t next_seq_state;

    wire logic [3:0] rate_select       = ctrl_a[3:0];
    wire logic       freeze            = ctrl_b[`RTIA_B_FREEZE];
    wire logic       periodic_int_enable = ctrl_b[`RTIA_B_PER_EN];
    wire logic       alarm_int_enable  = ctrl_b[`RTIA_B_ALM_EN];
    wire logic       update_int_enable = ctrl_b[`RTIA_B_UPD_EN];

    assign rd_flags = rd_i && (addr_i == `RTIA_OFF_FLAGS);

    rtia_divider #(
        .PRESCALE      (PRESCALE)
    ) u_divider (
        .clk_sys_i     (clk_sys_i),
        .rstn_i        (rstn_i),
        .rate_select_i (rate_select),
        .periodic_ev_o (periodic_ev),
        .second_tick_o (second_tick)
    );

    // Software register writes
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_a   <= `RTIA_RST_CTRL_A;
            ctrl_b   <= `RTIA_RST_CTRL_B;
            alm_sec  <= `RTIA_RST_ALARM;
            alm_min  <= `RTIA_RST_ALARM;
            alm_hour <= `RTIA_RST_ALARM;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `RTIA_OFF_CTRL_A:   ctrl_a   <= {1'b0, 3'b000, wdata_i[3:0]};
                `RTIA_OFF_CTRL_B:   ctrl_b   <= wdata_i;
                `RTIA_OFF_ALM_SEC:  alm_sec  <= wdata_i;
                `RTIA_OFF_ALM_MIN:  alm_min  <= wdata_i;
                `RTIA_OFF_ALM_HOUR: alm_hour <= wdata_i;
                default:            ctrl_a   <= ctrl_a;
            endcase
        end
    end

    // Update sequencer: in-progress window, then the short update transfer
    always_comb
    begin
        next_seq_state = seq_state;
        case (seq_state)
            rtia_pkg::RTIA_SEQ_IDLE:
                if (second_tick)
                    next_seq_state = rtia_pkg::RTIA_SEQ_PRE;
            rtia_pkg::RTIA_SEQ_PRE:
                if (seq_cnt == 16'(PRE_UPDATE_CYC - 1))
                    next_seq_state = rtia_pkg::RTIA_SEQ_UPD;
            rtia_pkg::RTIA_SEQ_UPD:
                if (seq_cnt == 16'(UPDATE_CYC - 1))
                    next_seq_state = rtia_pkg::RTIA_SEQ_IDLE;
            default:
                next_seq_state = rtia_pkg::RTIA_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            seq_state <= rtia_pkg::RTIA_SEQ_IDLE;
            seq_cnt   <= 16'h0;
        end
        else
        begin
            seq_state <= next_seq_state;
            seq_cnt   <= (next_seq_state != seq_state) ? 16'h0 : seq_cnt + 16'h1;
        end
    end

    // The cycle runs every second even while frozen; the time advance and the in-progress bit are held back
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            time_advance_o <= 1'b0;
            update_ev      <= 1'b0;
            uip            <= 1'b0;
        end
        else
        begin
            time_advance_o <= (seq_state == rtia_pkg::RTIA_SEQ_PRE) &&
                              (next_seq_state == rtia_pkg::RTIA_SEQ_UPD) && !freeze;
            update_ev      <= (seq_state == rtia_pkg::RTIA_SEQ_UPD) &&
                              (next_seq_state == rtia_pkg::RTIA_SEQ_IDLE);
            uip            <= (next_seq_state != rtia_pkg::RTIA_SEQ_IDLE) && !freeze;
        end
    end

    // Compare at the end of the update, when the time bytes have settled
    rtia_alarm_cmp u_alarm_cmp (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .compare_i  (update_ev),
        .alm_sec_i  (alm_sec),
        .alm_min_i  (alm_min),
        .alm_hour_i (alm_hour),
        .cur_sec_i  (cur_sec_i),
        .cur_min_i  (cur_min_i),
        .cur_hour_i (cur_hour_i),
        .match_o    (alarm_ev)
    );

    assign events  = {periodic_ev, alarm_ev, update_ev};
    assign enables = {periodic_int_enable,
                      alarm_int_enable,
                      update_int_enable && !freeze};
    assign pend    = |(flags & enables);

    // Flags never look at the enables, so polling works with all interrupts off
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            flags <= 3'b000;
            held  <= 3'b000;
        end
        else if (rd_flags)
        begin
            flags <= 3'b000;
            held  <= held | events;
        end
        else
        begin
            flags <= flags | events | held;
            held  <= 3'b000;
        end
    end

    // Open-drain pin: only ever pulls low, released otherwise
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_oe_o  <= 1'b0;
            irq_out_o <= 1'b0;
        end
        else
        begin
            irq_oe_o  <= pend;
            irq_out_o <= 1'b0;
        end
    end

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (!rd_i)
            rdata_o <= 8'h00;
        else
        begin
            case (addr_i)
                `RTIA_OFF_CTRL_A:   rdata_o <= {uip, 3'b000, rate_select};
                `RTIA_OFF_CTRL_B:   rdata_o <= ctrl_b;
                `RTIA_OFF_FLAGS:    rdata_o <= {irq_oe_o, flags, 4'h0};
                `RTIA_OFF_SEC:      rdata_o <= cur_sec_i;
                `RTIA_OFF_ALM_SEC:  rdata_o <= alm_sec;
                `RTIA_OFF_MIN:      rdata_o <= cur_min_i;
                `RTIA_OFF_ALM_MIN:  rdata_o <= alm_min;
                `RTIA_OFF_HOUR:     rdata_o <= cur_hour_i;
                `RTIA_OFF_ALM_HOUR: rdata_o <= alm_hour;
                default:            rdata_o <= 8'h00;
            endcase
        end
    end

    chk_flag_on_event: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (periodic_ev && !rd_flags) |=> flags[2])
        else $error("periodic event did not set its flag");

    chk_flag_no_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (update_ev && !rd_flags && !update_int_enable) |=> flags[0])
        else $error("update flag not set with enable off");

    chk_read_clears: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_flags |=> (flags == 3'b000))
        else $error("flag read did not clear the flags");

    chk_read_snapshot: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_flags |=> (rdata_o[6:0] == {$past(flags), 4'h0}))
        else $error("flag read data differ from the latched flags");

    chk_held_event: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_flags && periodic_ev) |=> held[2])
        else $error("event during flag read was lost");

    chk_held_release: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (held[2] && !rd_flags) |=> flags[2])
        else $error("held event not set after the flag read");

    chk_irq_follow: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        1'b1 |=> (irq_oe_o == $past(pend)))
        else $error("interrupt pin does not follow flag and enable");

    chk_irq_hold: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (pend && !rd_flags) [*2] |=> irq_oe_o)
        else $error("interrupt pin dropped while a pair is set");

    chk_summary_bit: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_flags |=> (rdata_o[`RTIA_F_SUMMARY] == $past(irq_oe_o)))
        else $error("summary bit differs from the pin state");

    chk_irq_release: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_flags |=> ##1 !irq_oe_o)
        else $error("interrupt pin not released after flag read");

    chk_periodic_off: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (rate_select == 4'h0 && $past(rate_select) == 4'h0) |-> !periodic_ev)
        else $error("periodic event with rate code zero");

    chk_update_gate: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (flags == 3'b001 && freeze) |=> !irq_oe_o)
        else $error("update interrupt raised while frozen");

    chk_pre_update: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (seq_state == rtia_pkg::RTIA_SEQ_UPD && $past(seq_state) == rtia_pkg::RTIA_SEQ_PRE)
        |-> ($past(seq_cnt) == 16'(PRE_UPDATE_CYC - 1)))
        else $error("update began before the in-progress lead");

    chk_update_len: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        update_ev |-> ($past(seq_cnt) == 16'(UPDATE_CYC - 1)))
        else $error("update cycle length wrong");

    chk_late_enable: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_i && addr_i == `RTIA_OFF_CTRL_B && wdata_i[`RTIA_B_PER_EN] && flags[2] && !rd_flags)
        |=> ##1 irq_oe_o)
        else $error("enabling a set flag did not raise the interrupt");

    chk_periodic_irq: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (periodic_ev && periodic_int_enable && !rd_flags &&
         !(wr_i && addr_i == `RTIA_OFF_CTRL_B)) |=> ##1 irq_oe_o)
        else $error("enabled periodic event did not raise the interrupt");

    chk_alarm_irq: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (alarm_ev && alarm_int_enable && !rd_flags &&
         !(wr_i && addr_i == `RTIA_OFF_CTRL_B)) |=> ##1 irq_oe_o)
        else $error("enabled alarm event did not raise the interrupt");

    chk_update_irq: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (update_ev && update_int_enable && !freeze && !rd_flags &&
         !(wr_i && addr_i == `RTIA_OFF_CTRL_B)) |=> ##1 irq_oe_o)
        else $error("enabled update event did not raise the interrupt");

    chk_update_flag: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (update_ev && !rd_flags) |=> flags[0])
        else $error("update end did not set its flag");

    chk_flags_low_zero: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rd_flags |=> (rdata_o[3:0] == 4'h0))
        else $error("unused flag bits read nonzero");

endmodule : rtia_core

//--- dv/rtia_host_model.sv
// Host processor model: register port master, interrupt pin pull-up and handler read
`include "rtia_consts.svh"

module rtia_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       irq_out_i,
    input  wire logic       irq_oe_i,
    output logic      [3:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output wire logic       irq_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Open-drain line with a pull-up: high whenever the device lets go
    assign irq_n_o = irq_oe_i ? irq_out_i : 1'b1;

    initial
    begin
        addr_o  = 4'h0;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    task write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        wr_o    <= 1'b0;
    endtask : write

    // Data is taken mid-cycle, well clear of the edge that returns it to zero
    task read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        rd_o   <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_i;
    endtask : read

    task burst(input logic [3:0] a, input int n);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        rd_o   <= 1'b0;
    endtask : burst

    // Handler: one flag read clears everything, then let the pin settle
    task isr(output logic [7:0] f);
        read(`RTIA_OFF_FLAGS, f);
        repeat (3) @(posedge clk_sys_i);
    endtask : isr

endmodule : rtia_host_model

//--- dv/rtc_interrupt_alarm_logic_tb.sv
// Self-checking bench for the interrupt, alarm and update-cycle block
`include "rtia_consts.svh"

module rtc_interrupt_alarm_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PS = 2;
    localparam int PU = 8;
    localparam int UC = 4;

    logic       clk_sys_i = 1'b0;
    logic       rstn_i    = 1'b0;
    logic [7:0] cur_sec   = 8'h30;
    logic [7:0] cur_min   = 8'h12;
    logic [7:0] cur_hour  = 8'h07;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata_o;
    logic       time_advance_o;
    logic       irq_out_o;
    logic       irq_oe_o;
    wire logic  irq_n;
    int         errors   = 0;
    int         n_checks = 0;

    rtia_core #(.PRESCALE(PS), .PRE_UPDATE_CYC(PU), .UPDATE_CYC(UC)) i_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .cur_sec_i(cur_sec),
        .cur_min_i(cur_min), .cur_hour_i(cur_hour), .time_advance_o(time_advance_o),
        .irq_out_o(irq_out_o), .irq_oe_o(irq_oe_o)
    );

    rtia_host_model i_host (
        .clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .irq_out_i(irq_out_o),
        .irq_oe_i(irq_oe_o), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .irq_n_o(irq_n)
    );

    initial
    begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // Stand-in for the external time counter: seconds advance on request
    always @(posedge clk_sys_i)
    begin
        if (time_advance_o === 1'b1)
            cur_sec <= cur_sec + 8'h01;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task wait_irq(input int lim, output int c);
        c = 0;
        while (irq_oe_o !== 1'b1 && c < lim)
        begin
            @(posedge clk_sys_i);
            c++;
        end
    endtask : wait_irq

    task t_registers;
        logic [3:0] a [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hf};
        logic [7:0] d;
        foreach (a[i])
        begin
            i_host.read(a[i], d);
            check(d, 8'h00);
        end
        i_host.write(`RTIA_OFF_CTRL_A, 8'hff);
        i_host.read(`RTIA_OFF_CTRL_A, d);
        check(d, 8'h0f);
        i_host.write(`RTIA_OFF_CTRL_B, 8'h0f);
        i_host.read(`RTIA_OFF_CTRL_B, d);
        check(d, 8'h0f);
        i_host.write(`RTIA_OFF_ALM_MIN, 8'h5a);
        i_host.read(`RTIA_OFF_ALM_MIN, d);
        check(d, 8'h5a);
        i_host.write(`RTIA_OFF_CTRL_A, 8'h00);
        i_host.write(`RTIA_OFF_CTRL_B, 8'h00);
        i_host.write(`RTIA_OFF_FLAGS, 8'hff);
        i_host.read(`RTIA_OFF_FLAGS, d);
        check(d & 8'h0f, 8'h00);
        check(irq_oe_o, 1'b0);
    endtask : t_registers

    task t_periodic_rates;
        logic [3:0] code [5] = '{4'h3, 4'h4, 4'h7, 4'h1, 4'hb};
        int         ticks [5] = '{4, 8, 64, 128, 1024};
        logic [7:0] f;
        int         c;
        time        t1;
        i_host.write(`RTIA_OFF_CTRL_B, 8'h40);
        foreach (code[i])
        begin
            i_host.write(`RTIA_OFF_CTRL_A, {4'h0, code[i]});
            wait_irq(ticks[i] * PS * 3, c);
            i_host.isr(f);
            wait_irq(ticks[i] * PS * 3, c);
            t1 = $time;
            check(irq_n, 1'b0);
            i_host.isr(f);
            check(f, 8'hc0);
            wait_irq(ticks[i] * PS * 3, c);
            check(($time - t1) / 20, ticks[i] * PS);
            i_host.isr(f);
        end
        i_host.write(`RTIA_OFF_CTRL_A, 8'h00);
        i_host.isr(f);
        repeat (600) @(posedge clk_sys_i);
        check(irq_oe_o, 1'b0);
        i_host.read(`RTIA_OFF_FLAGS, f);
        check(f, 8'h00);
    endtask : t_periodic_rates

    task t_poll_and_enable;
        logic [7:0] f;
        int         c;
        i_host.write(`RTIA_OFF_CTRL_B, 8'h00);
        i_host.write(`RTIA_OFF_CTRL_A, 8'h03);
        repeat (20) @(posedge clk_sys_i);
        check(irq_oe_o, 1'b0);
        i_host.write(`RTIA_OFF_CTRL_B, 8'h40);
        wait_irq(3, c);
        check(irq_oe_o, 1'b1);
        i_host.write(`RTIA_OFF_CTRL_B, 8'h00);
        repeat (2) @(posedge clk_sys_i);
        check(irq_oe_o, 1'b0);
        repeat (20) @(posedge clk_sys_i);
        i_host.read(`RTIA_OFF_FLAGS, f);
        check(f, 8'h40);
    endtask : t_poll_and_enable

    task t_read_hold;
        logic [7:0] f;
        repeat (20) @(posedge clk_sys_i);
        i_host.burst(`RTIA_OFF_FLAGS, 16);
        i_host.read(`RTIA_OFF_FLAGS, f);
        check(f & 8'h40, 8'h40);
        i_host.write(`RTIA_OFF_CTRL_A, 8'h00);
        repeat (20) @(posedge clk_sys_i);
        i_host.read(`RTIA_OFF_FLAGS, f);
        i_host.read(`RTIA_OFF_FLAGS, f);
        check(f, 8'h00);
    endtask : t_read_hold

    task t_update_alarm;
        logic [7:0] d;
        int         n;
        int         c;
        i_host.write(`RTIA_OFF_ALM_SEC, 8'hc5);
        i_host.write(`RTIA_OFF_ALM_MIN, 8'h12);
        i_host.write(`RTIA_OFF_ALM_HOUR, 8'hff);
        i_host.write(`RTIA_OFF_CTRL_B, 8'h30);
        d = 8'h00;
        n = 0;
        while (d[`RTIA_A_UIP] !== 1'b1 && n < 40000)
        begin
            i_host.read(`RTIA_OFF_CTRL_A, d);
            n++;
        end
        check(d[`RTIA_A_UIP], 1'b1);
        c = 0;
        while (time_advance_o !== 1'b1 && c < 100)
        begin
            @(posedge clk_sys_i);
            c++;
        end
        // Polling adds up to four cycles of lag before the lead is seen
        check(c <= PU && c + 4 >= PU, 1'b1);
        wait_irq(UC + 4, c);
        check(irq_oe_o, 1'b1);
        check(cur_sec, 8'h31);
        repeat (2) @(posedge clk_sys_i);
        i_host.read(`RTIA_OFF_FLAGS, d);
        check(d, 8'hb0);
        repeat (2) @(posedge clk_sys_i);
        check(irq_oe_o, 1'b0);
        check(irq_n, 1'b1);
    endtask : t_update_alarm

    initial
    begin
        repeat (90000) @(posedge clk_sys_i);
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        t_registers();
        t_periodic_rates();
        t_poll_and_enable();
        t_read_hold();
        t_update_alarm();
        complete_run();
    end

endmodule : rtc_interrupt_alarm_logic_tb
